/* File: core/cefr_defs.vh */
`ifndef CEFR_DEFS_VH
`define CEFR_DEFS_VH

// ==========================================================
// register map (offsets are word indices, one apart, not byte index * 4)
`define CEFR_IDX_FLAGS_TWO      8'h24
`define CEFR_IDX_FLAGS_THREE    8'h25
`define CEFR_IDX_FAULT_ZERO     8'h26
`define CEFR_RESET_VAL          8'h00

// ==========================================================
// flags two fields
`define CEFR_F2_DPDM            6
`define CEFR_F2_ADC             5
`define CEFR_F2_VSYS            4
`define CEFR_F2_FAST            3
`define CEFR_F2_TRICKLE         2
`define CEFR_F2_PRE             1
`define CEFR_F2_TOPOFF          0

// ==========================================================
// flags three fields
`define CEFR_F3_BATLOW          4
`define CEFR_F3_COLD            3
`define CEFR_F3_COOL            2
`define CEFR_F3_WARM            1
`define CEFR_F3_HOT             0
`define CEFR_F3_USED_MASK       8'h1f

// ==========================================================
// misc
`define CEFR_RDATA_ZERO         32'h00000000
`define CEFR_NUM_EVENTS         24

`endif

/* File: core/cefr_edge_latch.v */
`timescale 1ns/1ps
// ==========================================================
// one sticky flag per bit, set from a chosen edge, cleared on read
module cefr_edge_latch #(
   parameter WIDTH     = 8,
   parameter BOTH_MASK = 8'h00,
   parameter FALL_MASK = 8'h00
) (
   // clock and reset
   input  wire             clk,
   input  wire             rst_b,
   // event levels, already synchronised
   input  wire [WIDTH-1:0] level,
   // read clear
   input  wire             rd_clr,
   // stored flags
   output wire [WIDTH-1:0] flags
);

   reg  [WIDTH-1:0] last_ff;
   reg  [WIDTH-1:0] flag_ff;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         wire rise;
         wire fall;
         wire hit;
         assign rise = level[i] & ~last_ff[i];
         assign fall = ~level[i] & last_ff[i];
         assign hit  = BOTH_MASK[i] ? (rise | fall) : (FALL_MASK[i] ? fall : rise);
         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               last_ff[i] <= 1'b0;
               flag_ff[i] <= 1'b0;
            end else begin
               last_ff[i] <= level[i];
               // set beats the read clear
               if (hit)
                  flag_ff[i] <= 1'b1;
               else if (rd_clr)
                  flag_ff[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flags = flag_ff;

endmodule

/* File: core/cefr_flag_regs.v */
`timescale 1ns/1ps
`include "cefr_defs.vh"

module cefr_flag_regs (
   // clock and reset
   input  wire        clk,
   input  wire        rst_b,
   // avalon-mm slave
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   output reg  [1:0]  avs_response,
   // charger event levels, asynchronous
   input  wire        data_line_detect_complete,
   input  wire        adc_conversion_done,
   input  wire        adc_one_shot_mode,
   input  wire        min_system_voltage_reg_active,
   input  wire        fast_charge_timeout,
   input  wire        trickle_timeout,
   input  wire        precharge_timeout,
   input  wire        top_off_timeout,
   input  wire        battery_low_for_boost_output,
   input  wire        thermistor_cold_cross,
   input  wire        thermistor_cool_cross,
   input  wire        thermistor_warm_cross,
   input  wire        thermistor_hot_cross,
   input  wire        battery_current_reg_active,
   input  wire        input_bus_overvoltage,
   input  wire        battery_overvoltage,
   input  wire        input_bus_overcurrent,
   input  wire        battery_discharge_overcurrent,
   input  wire        converter_overcurrent,
   input  wire        second_adapter_overvoltage,
   input  wire        first_adapter_overvoltage,
   // flag views
   output wire [7:0]  charger_event_flags_two,
   output wire [7:0]  charger_event_flags_three,
   output wire [7:0]  protection_fault_flags_zero
);

   // ==========================================================
   // input synchronisers
   wire [`CEFR_NUM_EVENTS-1:0] ev_raw;
   reg  [`CEFR_NUM_EVENTS-1:0] sync1_ff;
   reg  [`CEFR_NUM_EVENTS-1:0] sync2_ff;

   // unused slots tied low keep all three banks one shape
   assign ev_raw = {battery_current_reg_active, input_bus_overvoltage, battery_overvoltage,
                    input_bus_overcurrent, battery_discharge_overcurrent,
                    converter_overcurrent, second_adapter_overvoltage,
                    first_adapter_overvoltage,
                    3'h0, battery_low_for_boost_output, thermistor_cold_cross,
                    thermistor_cool_cross, thermistor_warm_cross, thermistor_hot_cross,
                    adc_one_shot_mode, data_line_detect_complete, adc_conversion_done,
                    min_system_voltage_reg_active, fast_charge_timeout, trickle_timeout,
                    precharge_timeout, top_off_timeout};

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_ff <= {`CEFR_NUM_EVENTS{1'b0}};
         sync2_ff <= {`CEFR_NUM_EVENTS{1'b0}};
      end else begin
         sync1_ff <= ev_raw;
         sync2_ff <= sync1_ff;
      end
   end

   // ==========================================================
   // event qualification for flags two
   wire [7:0] lvl_two;
   wire [7:0] lvl_three;
   wire [7:0] lvl_fault;
   wire       one_shot_s;

   reg        adc_prev_ff;

   // gate the done edge, not the level: a mode change alone is no conversion
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         adc_prev_ff <= 1'b0;
      else
         adc_prev_ff <= sync2_ff[5];
   end

   assign one_shot_s = sync2_ff[7];
   assign lvl_two[`CEFR_F2_ADC]     = sync2_ff[5] & ~adc_prev_ff & one_shot_s;
   assign lvl_two[`CEFR_F2_DPDM]    = sync2_ff[6];
   assign lvl_two[`CEFR_F2_VSYS]    = sync2_ff[4];
   assign lvl_two[`CEFR_F2_FAST]    = sync2_ff[3];
   assign lvl_two[`CEFR_F2_TRICKLE] = sync2_ff[2];
   assign lvl_two[`CEFR_F2_PRE]     = sync2_ff[1];
   assign lvl_two[`CEFR_F2_TOPOFF]  = sync2_ff[0];
   assign lvl_two[7]                = 1'b0;

   assign lvl_three = sync2_ff[15:8];
   assign lvl_fault = sync2_ff[23:16];

   // ==========================================================
   // avalon slave: one-cycle wait, answer at second edge
   reg        pend_ff;
   wire       req;
   wire       acc;
   wire       rd_two;
   wire       rd_three;
   wire       rd_fault;

   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~pend_ff;
   assign acc             = req & ~pend_ff;

   // clear at the snapshot edge so an event after it is never lost
   // read clears its register
   assign rd_two   = acc & avs_read & (avs_address == `CEFR_IDX_FLAGS_TWO);
   assign rd_three = acc & avs_read & (avs_address == `CEFR_IDX_FLAGS_THREE);
   assign rd_fault = acc & avs_read & (avs_address == `CEFR_IDX_FAULT_ZERO);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         pend_ff <= 1'b0;
      else
         pend_ff <= req & ~pend_ff;
   end

   // ==========================================================
   // flag banks; writes never reach them
   // no write path
   cefr_edge_latch #(
      .WIDTH     (8),
      .BOTH_MASK (8'h10),
      .FALL_MASK (8'h00)
   ) u_two (
      .clk    (clk),
      .rst_b  (rst_b),
      .level  (lvl_two),
      .rd_clr (rd_two),
      .flags  (charger_event_flags_two)
   );

   // falling battery seen as rise of low level
   // thermistor crossings count either direction
   cefr_edge_latch #(
      .WIDTH     (8),
      .BOTH_MASK (8'h0f),
      .FALL_MASK (8'h00)
   ) u_three (
      .clk    (clk),
      .rst_b  (rst_b),
      .level  (lvl_three),
      .rd_clr (rd_three),
      .flags  (charger_event_flags_three)
   );

   cefr_edge_latch #(
      .WIDTH     (8),
      .BOTH_MASK (8'h80),
      .FALL_MASK (8'h00)
   ) u_fault (
      .clk    (clk),
      .rst_b  (rst_b),
      .level  (lvl_fault),
      .rd_clr (rd_fault),
      .flags  (protection_fault_flags_zero)
   );

   // ==========================================================
   // read data, captured while waitrequest is high
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= `CEFR_RDATA_ZERO;
         avs_response <= 2'h0;
      end else if (acc) begin
         avs_response <= 2'h0;
         if (avs_address == `CEFR_IDX_FLAGS_TWO)
            avs_readdata <= {24'h000000, charger_event_flags_two};
         else if (avs_address == `CEFR_IDX_FLAGS_THREE)
            avs_readdata <= {24'h000000,
                             charger_event_flags_three & `CEFR_F3_USED_MASK};
         else if (avs_address == `CEFR_IDX_FAULT_ZERO)
            avs_readdata <= {24'h000000, protection_fault_flags_zero};
         else begin
            // unmapped: zero data, slave error
            avs_readdata <= `CEFR_RDATA_ZERO;
            avs_response <= 2'h2;
         end
      end
   end

endmodule

/* File: bench/cefr_flag_regs_monitor.sv */
`timescale 1ns/1ps
// ==========================================================
// slave port checks
module cefr_flag_regs_monitor (
   // clock and reset
   input wire        clk,
   input wire        rst_b,
   // bus
   input wire [7:0]  avs_address,
   input wire        avs_read,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   // events
   input wire        adc_conversion_done,
   input wire        adc_one_shot_mode,
   input wire        fast_charge_timeout,
   input wire        thermistor_hot_cross,
   input wire        first_adapter_overvoltage,
   // flags
   input wire [7:0]  charger_event_flags_two,
   input wire [7:0]  charger_event_flags_three,
   input wire [7:0]  protection_fault_flags_zero
);
   wire        rd_end = avs_read && !avs_waitrequest;
   wire [23:0] all_f  = {charger_event_flags_two, charger_event_flags_three,
                         protection_fault_flags_zero};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // two sync stages, then the edge detect
   sequence s_late(x);
      ##[2:4] x;
   endsequence
   property p_resv;
      charger_event_flags_two[7] == 1'b0 && charger_event_flags_three[7:5] == 3'h0;
   endproperty
   property p_hold;
      !(avs_read && avs_waitrequest) |=> (all_f & $past(all_f)) == $past(all_f);
   endproperty
   property p_clear;
      rd_end && avs_address == 8'h24 |=> charger_event_flags_two == 8'h00;
   endproperty
   property p_snap;
      avs_read && avs_waitrequest && avs_address == 8'h26
         |=> avs_readdata == {24'h0, $past(protection_fault_flags_zero)};
   endproperty
   property p_fast;
      $rose(fast_charge_timeout) |-> s_late(charger_event_flags_two[3]);
   endproperty
   property p_adc;
      $rose(adc_conversion_done) && adc_one_shot_mode |-> s_late(charger_event_flags_two[5]);
   endproperty
   property p_hot;
      $changed(thermistor_hot_cross) |-> s_late(charger_event_flags_three[0]);
   endproperty
   property p_fault;
      $rose(first_adapter_overvoltage) |-> s_late(protection_fault_flags_zero[0]);
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bit set");
   a_hold: assert property (p_hold) else $error("flag lost");
   a_clear: assert property (p_clear) else $error("read no clear");
   a_snap: assert property (p_snap) else $error("read data wrong");
   a_fast: assert property (p_fast) else $error("fast flag");
   a_adc: assert property (p_adc) else $error("adc flag");
   a_hot: assert property (p_hot) else $error("hot flag");
   a_fault: assert property (p_fault) else $error("adapter flag");
endmodule
bind cefr_flag_regs cefr_flag_regs_monitor u_mon (.*);

/* File: bench/cefr_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// host side master, one transfer per call
module cefr_host_model (
   input  wire        clk,
   output reg  [7:0]  avs_address,
   output reg         avs_read,
   output reg         avs_write,
   output reg  [31:0] avs_writedata,
   output reg  [3:0]  avs_byteenable,
   input  wire [31:0] avs_readdata,
   input  wire        avs_waitrequest,
   input  wire [1:0]  avs_response
);
   initial {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
   // idle cycle after each call keeps strobe edges apart
   task automatic xfer(input bit wr, input [7:0] a, input [31:0] d,
                       output [31:0] q, output [1:0] r);
      int n;
      begin
         n = 0;
         @(posedge clk);
         {avs_address, avs_writedata, avs_byteenable} <= {a, d, 4'hf};
         {avs_read, avs_write} <= {!wr, wr};
         do begin
            @(posedge clk);
            n++;
         end while (avs_waitrequest !== 1'b0 && n < 64);
         q = avs_readdata;
         r = avs_response;
         // released lines carry no stale value
         {avs_read, avs_write, avs_address, avs_writedata} <= {2'b00, ~a, ~d};
      end
   endtask
endmodule

/* File: bench/cefr_flag_regs_tb.sv */
`timescale 1ns/1ps
module cefr_flag_regs_tb;
   // ==========================================================
   // signals
   reg          clk = 1'b0;
   reg          rst_b = 1'b0;
   reg          adc_one_shot_mode = 1'b0;
   reg  [19:0]  ev = 20'h0;
   wire [7:0]   avs_address;
   wire         avs_read;
   wire         avs_write;
   wire [31:0]  avs_writedata;
   wire [3:0]   avs_byteenable;
   wire [31:0]  avs_readdata;
   wire         avs_waitrequest;
   wire [1:0]   avs_response;
   wire [7:0]   charger_event_flags_two;
   wire [7:0]   charger_event_flags_three;
   wire [7:0]   protection_fault_flags_zero;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          model [3] = '{0, 0, 0};
   logic [31:0] q;
   logic [1:0]  r;
   always #10 clk = ~clk;
   cefr_host_model host (.*);
   cefr_flag_regs DUT (.*,
      .data_line_detect_complete(ev[0]), .adc_conversion_done(ev[1]),
      .min_system_voltage_reg_active(ev[2]), .fast_charge_timeout(ev[3]),
      .trickle_timeout(ev[4]), .precharge_timeout(ev[5]), .top_off_timeout(ev[6]),
      .battery_low_for_boost_output(ev[7]), .thermistor_cold_cross(ev[8]),
      .thermistor_cool_cross(ev[9]), .thermistor_warm_cross(ev[10]),
      .thermistor_hot_cross(ev[11]), .battery_current_reg_active(ev[12]),
      .input_bus_overvoltage(ev[13]), .battery_overvoltage(ev[14]),
      .input_bus_overcurrent(ev[15]), .battery_discharge_overcurrent(ev[16]),
      .converter_overcurrent(ev[17]), .second_adapter_overvoltage(ev[18]),
      .first_adapter_overvoltage(ev[19]));
   // ==========================================================
   // tasks
   task chk(input [31:0] seen, input [31:0] exp, input string what);
      begin
         samples_checked++;
         if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task automatic apply(input [19:0] nv, input bit os);
      int i, g, b;
      begin
         for (i = 0; i < 20; i++) begin
            g = (i < 7) ? 0 : (i < 12) ? 1 : 2;
            b = (i < 7) ? 6 - i : (i < 12) ? 11 - i : 19 - i;
            if ((nv[i] && !ev[i]) || (nv[i] != ev[i] && (i == 2 || (i > 7 && i < 13))))
               if (i != 1 || os)
                  model[g] |= 1 << b;
         end
         @(posedge clk);
         ev <= nv;
         adc_one_shot_mode <= os;
         repeat (6) @(posedge clk);
      end
   endtask
   task automatic rd_all;
      int k;
      for (k = 0; k < 3; k++) begin
         host.xfer(1'b0, 8'(36 + k), 32'h0, q, r);
         chk(q, model[k], "flag register");
         chk({30'h0, r}, 32'h0, "read response");
         model[k] = 0;
      end
   endtask
   task wrap_up;
      begin
         $display("checked %0d mismatches %0d", samples_checked, mismatches);
         if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // ==========================================================
   // sequence and watchdog
   initial begin
      #400000;
      mismatches++;
      wrap_up();
   end
   initial begin
      int n, k;
      void'($urandom(32'hb5513ed4));
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd_all();
      $display("test reset done");
      host.xfer(1'b0, 8'h27, 32'h0, q, r);
      chk(q, 32'h0, "unmapped data");
      chk({30'h0, r}, 32'h2, "unmapped read response");
      host.xfer(1'b1, 8'h23, $urandom, q, r);
      chk({30'h0, r}, 32'h2, "unmapped write response");
      $display("test unmapped done");
      for (n = 0; n < 60; n++) begin
         apply(20'($urandom), 1'($urandom));
         for (k = 0; k < 3 && n % 3 == 0; k++) begin
            host.xfer(1'b1, 8'(36 + k), $urandom, q, r);
            chk({30'h0, r}, 32'h0, "write response");
         end
         rd_all();
      end
      $display("test random events done");
      wrap_up();
   end
endmodule
